// *** design/ifeb_top.sv ***
/*
 * Interrupt flag and enable bank: flag status 4, enable registers 0 to 3,
 * per-flag enable and priority, gating toward priority arbitration, and a
 * sticky event status with mask and one interrupt line, on AXI4-Lite.
 * Assumes request inputs are synchronous to aclk and held one cycle or more.
 */
// The address map and the AXI4-Lite register port were left to the implementer.
// Functional notes
// - Flag status 4 holds checksum at bit 3, second serial error at 2, first at 1.
// - Unimplemented bits of flag and enable registers read zero and ignore writes.
// - An enable bit at one lets its source's request act; at zero it is held off.
// - Enable 0 holds bits 13..5 and 3..0 in the documented order, bit 4 unused.
// - Enable 1 holds bits 15..9 and 4..0, bits 8..5 unused.
// - Enable 2 holds bits 13, 9, 7..5, 1 and 0, all others unused.
// - Enable 3 holds bits 14, 6, 5, 2 and 1, all others read zero.
// - Implemented bits of flag and enable registers are read/write, reset to zero, and a written zero clears a flag.
// - A three-bit priority per source, 7 highest, 1 lowest, 0 disables the source.
`timescale 1ns/1ps

module ifeb_top #(
    parameter int NUM_FLAGS = 3
) (
    // Clock, reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address channel
    input wire logic [ifeb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [ifeb_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [ifeb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [ifeb_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral request sources
    input wire logic [NUM_FLAGS-1:0] flag_raise,
    input wire logic [4*16-1:0] source_request,
    // Toward priority arbitration
    output logic [NUM_FLAGS-1:0] forward_request,
    output logic [3*NUM_FLAGS-1:0] forward_priority,
    output logic [4*16-1:0] enabled_request,
    // Interrupt line
    output logic irq
);

    // Decode a byte address to a register selector
    function automatic ifeb_pkg::ifeb_sel_t decode_addr(input logic [5:0] addr);
        ifeb_pkg::ifeb_sel_t sel;
        sel = ifeb_pkg::SEL_NONE;
        case (addr)
            ifeb_pkg::OFF_FLAG_STATUS_4: sel = ifeb_pkg::SEL_FLAG;
            ifeb_pkg::OFF_ENABLE_0: sel = ifeb_pkg::SEL_EN0;
            ifeb_pkg::OFF_ENABLE_1: sel = ifeb_pkg::SEL_EN1;
            ifeb_pkg::OFF_ENABLE_2: sel = ifeb_pkg::SEL_EN2;
            ifeb_pkg::OFF_ENABLE_3: sel = ifeb_pkg::SEL_EN3;
            ifeb_pkg::OFF_FLAG_ENABLE: sel = ifeb_pkg::SEL_FEN;
            ifeb_pkg::OFF_PRIORITY: sel = ifeb_pkg::SEL_PRIO;
            ifeb_pkg::OFF_EVENT_STATUS: sel = ifeb_pkg::SEL_STAT;
            ifeb_pkg::OFF_EVENT_MASK: sel = ifeb_pkg::SEL_MASK;
            default: sel = ifeb_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction : decode_addr

    // Merge written bytes into a 16-bit register, keeping only implemented bits
    function automatic logic [15:0] merge_write(
        input logic [15:0] old_val,
        input logic [15:0] wval,
        input logic [1:0] strb,
        input logic [15:0] impl
    );
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}};
        return ((old_val & ~lane) | (wval & lane)) & impl;
    endfunction : merge_write

    // Implemented-bit mask of each enable register
    localparam logic [4*16-1:0] ENABLE_MASKS = {ifeb_pkg::MASK_ENABLE_3,
        ifeb_pkg::MASK_ENABLE_2, ifeb_pkg::MASK_ENABLE_1, ifeb_pkg::MASK_ENABLE_0};

    // Bus state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_have_q;
    logic w_have_q;
    logic [5:0] waddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;

    // Register state
    logic [15:0] flag_q;
    logic [15:0] enable_q [ifeb_pkg::ENABLE_REGS];
    logic [15:0] flag_en_q;
    logic [15:0] prio_q;
    logic [15:0] event_q;
    logic [15:0] event_mask_q;

    // Output state
    logic [NUM_FLAGS-1:0] forward_q;
    logic [3*NUM_FLAGS-1:0] fwd_prio_q;
    logic [4*16-1:0] enabled_q;
    logic irq_q;

    // Handshake terms
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    ifeb_pkg::ifeb_sel_t wsel;
    ifeb_pkg::ifeb_sel_t rsel;
    logic [15:0] flag_set;
    logic [15:0] event_set;
    logic [NUM_FLAGS-1:0] forward_d;

    assign aw_take = ce & s_axi_awvalid & awready_q;
    assign w_take = ce & s_axi_wvalid & wready_q;
    assign ar_take = ce & s_axi_arvalid & arready_q;
    assign do_write = ce & aw_have_q & w_have_q & ~bvalid_q;
    assign wsel = decode_addr(waddr_q);
    assign rsel = decode_addr(s_axi_araddr);

    // Capture write address; one write in flight at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            waddr_q <= 6'h00;
        end
        else if (ce)
        begin
            if (aw_take)
            begin
                awready_q <= 1'b0;
                aw_have_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                awready_q <= 1'b1;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
            end
        end
    end

    // Capture write data, low halfword and its byte strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
        end
        else if (ce)
        begin
            if (w_take)
            begin
                wready_q <= 1'b0;
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata[15:0];
                wstrb_q <= s_axi_wstrb[1:0];
            end
            else if (bvalid_q && s_axi_bready)
            begin
                wready_q <= 1'b1;
            end
            if (do_write)
            begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response, error for an unmapped address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= ifeb_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == ifeb_pkg::SEL_NONE) ? ifeb_pkg::RESP_SLVERR
                                                        : ifeb_pkg::RESP_OKAY;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read path: data one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= ifeb_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= ifeb_pkg::RESP_OKAY;
                case (rsel)
                    ifeb_pkg::SEL_FLAG: rdata_q <= {16'h0000, flag_q};
                    ifeb_pkg::SEL_EN0: rdata_q <= {16'h0000, enable_q[0]};
                    ifeb_pkg::SEL_EN1: rdata_q <= {16'h0000, enable_q[1]};
                    ifeb_pkg::SEL_EN2: rdata_q <= {16'h0000, enable_q[2]};
                    ifeb_pkg::SEL_EN3: rdata_q <= {16'h0000, enable_q[3]};
                    ifeb_pkg::SEL_FEN: rdata_q <= {16'h0000, flag_en_q};
                    ifeb_pkg::SEL_PRIO: rdata_q <= {16'h0000, prio_q};
                    ifeb_pkg::SEL_STAT: rdata_q <= {16'h0000, event_q};
                    ifeb_pkg::SEL_MASK: rdata_q <= {16'h0000, event_mask_q};
                    default:
                    begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= ifeb_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (rvalid_q && s_axi_rready)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Flag raise pulses placed at their bit positions
    always_comb
    begin
        flag_set = 16'h0000;
        flag_set[ifeb_pkg::FLAG_HI:ifeb_pkg::FLAG_LO] = flag_raise;
    end

    // Flag status 4: software writes, sources set, set wins over a cleared bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_q <= ifeb_pkg::RST_FLAG;
        end
        else if (ce)
        begin
            if (do_write && wsel == ifeb_pkg::SEL_FLAG)
            begin
                flag_q <= merge_write(flag_q, wdata_q, wstrb_q,
                                      ifeb_pkg::MASK_FLAG_STATUS_4) | flag_set;
            end
            else
            begin
                flag_q <= flag_q | flag_set;
            end
        end
    end

    // Enable registers 0 to 3, each masked to its implemented bits
    generate
        for (genvar g = 0; g < ifeb_pkg::ENABLE_REGS; g++)
        begin : g_enable
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    enable_q[g] <= ifeb_pkg::RST_ENABLE;
                end
                else if (ce && do_write && wsel == ifeb_pkg::ifeb_sel_t'(10'h004 << g))
                begin
                    enable_q[g] <= merge_write(enable_q[g], wdata_q, wstrb_q,
                                               ENABLE_MASKS[g*16 +: 16]);
                end
            end

            // Requests of the enable-register sources pass only when enabled
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    enabled_q[g*16 +: 16] <= 16'h0000;
                end
                else if (ce)
                begin
                    enabled_q[g*16 +: 16] <= source_request[g*16 +: 16] & enable_q[g];
                end
            end
        end
    endgenerate

    // Flag enable and priority registers for the flag status 4 sources
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flag_en_q <= ifeb_pkg::RST_ENABLE;
            prio_q <= ifeb_pkg::RST_PRIORITY;
        end
        else if (ce && do_write)
        begin
            if (wsel == ifeb_pkg::SEL_FEN)
            begin
                flag_en_q <= merge_write(flag_en_q, wdata_q, wstrb_q,
                                         ifeb_pkg::MASK_FLAG_STATUS_4);
            end
            if (wsel == ifeb_pkg::SEL_PRIO)
            begin
                prio_q <= merge_write(prio_q, wdata_q, wstrb_q, ifeb_pkg::MASK_PRIORITY);
            end
        end
    end

    // Forward a flag only with its enable set and a nonzero priority
    generate
        for (genvar f = 0; f < NUM_FLAGS; f++)
        begin : g_forward
            assign forward_d[f] = flag_q[ifeb_pkg::FLAG_LO + f]
                & flag_en_q[ifeb_pkg::FLAG_LO + f]
                & (prio_q[f*ifeb_pkg::PRIO_STRIDE +: ifeb_pkg::PRIO_W]
                   != ifeb_pkg::PRIO_DISABLED);
        end
    endgenerate

    // Arbitration outputs registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            forward_q <= '0;
            fwd_prio_q <= '0;
        end
        else if (ce)
        begin
            forward_q <= forward_d;
            for (int i = 0; i < NUM_FLAGS; i++)
            begin
                fwd_prio_q[i*3 +: 3] <= forward_d[i]
                    ? prio_q[i*ifeb_pkg::PRIO_STRIDE +: ifeb_pkg::PRIO_W]
                    : ifeb_pkg::PRIO_DISABLED;
            end
        end
    end

    // Event bits: one per forwarded flag source
    always_comb
    begin
        event_set = 16'h0000;
        event_set[NUM_FLAGS-1:0] = forward_d;
    end

    // Sticky event status, cleared by a read, set wins over the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            event_q <= ifeb_pkg::RST_EVENT;
        end
        else if (ce)
        begin
            if (ar_take && rsel == ifeb_pkg::SEL_STAT)
            begin
                event_q <= event_set & ifeb_pkg::MASK_EVENT;
            end
            else
            begin
                event_q <= (event_q | event_set) & ifeb_pkg::MASK_EVENT;
            end
        end
    end

    // Event mask and the interrupt line
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            event_mask_q <= ifeb_pkg::RST_EVENT;
            irq_q <= 1'b0;
        end
        else if (ce)
        begin
            if (do_write && wsel == ifeb_pkg::SEL_MASK)
            begin
                event_mask_q <= merge_write(event_mask_q, wdata_q, wstrb_q,
                                            ifeb_pkg::MASK_EVENT);
            end
            irq_q <= |(event_q & event_mask_q);
        end
    end

    // Port drive
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign forward_request = forward_q;
    assign forward_priority = fwd_prio_q;
    assign enabled_request = enabled_q;
    assign irq = irq_q;

endmodule : ifeb_top

// *** design/ifeb_pkg.sv ***
/*
 * Package for the interrupt flag and enable bank: register byte offsets,
 * implemented-bit masks, reset values, field positions and bus codes.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package ifeb_pkg;

    // Register bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int ENABLE_REGS = 4;

    // Register byte offsets
    localparam logic [5:0] OFF_FLAG_STATUS_4 = 6'h00;
    localparam logic [5:0] OFF_ENABLE_0 = 6'h04;
    localparam logic [5:0] OFF_ENABLE_1 = 6'h08;
    localparam logic [5:0] OFF_ENABLE_2 = 6'h0C;
    localparam logic [5:0] OFF_ENABLE_3 = 6'h10;
    localparam logic [5:0] OFF_FLAG_ENABLE = 6'h14;
    localparam logic [5:0] OFF_PRIORITY = 6'h18;
    localparam logic [5:0] OFF_EVENT_STATUS = 6'h1C;
    localparam logic [5:0] OFF_EVENT_MASK = 6'h20;

    // Flag positions in flag status 4 (and in the flag enable register)
    localparam int POS_FIRST_SERIAL_ERROR = 1;
    localparam int POS_SECOND_SERIAL_ERROR = 2;
    localparam int POS_CHECKSUM_GENERATOR = 3;
    localparam int FLAG_LO = 1;
    localparam int FLAG_HI = 3;

    // Implemented-bit masks; every other position reads zero
    localparam logic [15:0] MASK_FLAG_STATUS_4 = 16'h000E;
    localparam logic [15:0] MASK_ENABLE_0 = 16'h3FEF;
    localparam logic [15:0] MASK_ENABLE_1 = 16'hFE1F;
    localparam logic [15:0] MASK_ENABLE_2 = 16'h22E3;
    localparam logic [15:0] MASK_ENABLE_3 = 16'h4066;
    localparam logic [15:0] MASK_PRIORITY = 16'h0777;
    localparam logic [15:0] MASK_EVENT = 16'h0007;

    // Priority field layout: three 3-bit fields, one per flag source
    localparam int PRIO_W = 3;
    localparam int PRIO_STRIDE = 4;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;

    // Reset values
    localparam logic [15:0] RST_FLAG = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_PRIORITY = 16'h0444;
    localparam logic [15:0] RST_EVENT = 16'h0000;

    // Response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register selector
    typedef enum logic [9:0] {
        SEL_NONE = 10'h001,
        SEL_FLAG = 10'h002,
        SEL_EN0 = 10'h004,
        SEL_EN1 = 10'h008,
        SEL_EN2 = 10'h010,
        SEL_EN3 = 10'h020,
        SEL_FEN = 10'h040,
        SEL_PRIO = 10'h080,
        SEL_STAT = 10'h100,
        SEL_MASK = 10'h200
    } ifeb_sel_t;

endpackage : ifeb_pkg

// *** tb/ifeb_checker.sv ***
/* Checker for ifeb_top: bus timing, request gating and forward priority.
   Assumes one clock domain and sees only the top module's ports. */
`timescale 1ns/1ps

module ifeb_checker #(
    parameter int NUM_FLAGS = 3
) (
    // Clock, reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ifeb_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Requests
    input wire logic [4*16-1:0] source_request,
    input wire logic [NUM_FLAGS-1:0] forward_request,
    input wire logic [3*NUM_FLAGS-1:0] forward_priority,
    input wire logic [4*16-1:0] enabled_request
);
    localparam logic [63:0] EN_IMPL = 64'h4066_22E3_FE1F_3FEF;
    logic [NUM_FLAGS-1:0] prio_nz;

    // Nonzero priority field of each source
    always_comb
        for (int i = 0; i < NUM_FLAGS; i++)
            prio_nz[i] = |forward_priority[3*i +: 3];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_EN_UNUSED: assert property ((enabled_request & ~EN_IMPL) == 64'h0)
        else $error("request passed at an unused position");
    AST_EN_GATE: assert property (
        $past(ce) |-> (enabled_request & ~$past(source_request)) == 64'h0)
        else $error("request passed without its source");
    AST_FWD_PRIO: assert property (forward_request == prio_nz)
        else $error("forward and priority disagree");
    AST_B_LAT: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce ##1 ce
        |-> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late or early");
    AST_AW_LOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken before response");
    AST_R_LAT: assert property (
        s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped while stalled");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
endmodule : ifeb_checker

bind ifeb_top ifeb_checker #(.NUM_FLAGS(NUM_FLAGS)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .source_request(source_request), .forward_request(forward_request),
    .forward_priority(forward_priority), .enabled_request(enabled_request)
);

// *** tb/ifeb_src_model.sv ***
/* Peripheral request sources: one-cycle flag raise pulses and held levels.
   Assumes the bench drives its commands by non-blocking assignment. */
`timescale 1ns/1ps

module ifeb_src_model (
    // Clock
    input wire logic aclk,
    // Commands from the bench
    input wire logic go,
    input wire logic [2:0] go_bits,
    input wire logic [63:0] level_in,
    // Toward the bank
    output logic [2:0] flag_raise = 3'h0,
    output logic [63:0] source_request = 64'h0
);
    // A source raises its flag for one cycle whatever the enables hold
    always @(posedge aclk)
        flag_raise <= go ? go_bits : 3'h0;
    // Request levels follow the bench one cycle late and stay
    always @(posedge aclk)
        source_request <= level_in;
endmodule : ifeb_src_model

// *** tb/tb_interrupt_flag_enable_bank.sv ***
/* Testbench for ifeb_top: AXI4-Lite master tasks, a response scoreboard
   and a request source model. Assumes one 250 MHz clock. */
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            err_total++; \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
        end \
    end

module tb_interrupt_flag_enable_bank;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] aw_a = 6'h00;
    logic [5:0] ar_a = 6'h00;
    logic [31:0] w_d = 32'h0;
    logic [3:0] w_s = 4'h0;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic b_r = 1'b0;
    logic ar_v = 1'b0;
    logic r_r = 1'b0;
    logic go = 1'b0;
    logic ce = 1'b1;
    logic [2:0] go_bits = 3'h0;
    logic [63:0] lvl = 64'h0;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
    logic [1:0] b_rsp, r_rsp, bexp;
    logic [31:0] r_d;
    logic [33:0] rexp;
    logic [2:0] fwd, raise;
    logic [8:0] fwd_p;
    logic [63:0] en_req, src, gate;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [15:0] en_v [4];
    logic [15:0] msk [4] = '{16'h3FEF, 16'hFE1F, 16'h22E3, 16'h4066};
    int err_total = 0;
    int samples_checked = 0;

    ifeb_top dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a),
        .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .flag_raise(raise), .source_request(src),
        .forward_request(fwd), .forward_priority(fwd_p),
        .enabled_request(en_req), .irq(irq)
    );
    ifeb_src_model srcs (
        .aclk(aclk), .go(go), .go_bits(go_bits), .level_in(lvl),
        .flag_raise(raise), .source_request(src)
    );

    // Clock
    initial
        forever #2 aclk = ~aclk;

    task automatic tally_and_finish();
        $display("counts: %0d checked, %0d wrong", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Write: both channels offered together, each released when taken
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] s);
        int n;
        bq.push_back(a > 6'h20 ? 2'h2 : 2'h0);
        @(posedge aclk);
        aw_a <= a;
        w_d <= {16'($urandom), d};
        w_s <= s;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (aw_rdy)
                aw_v <= 1'b0;
            if (w_rdy)
                w_v <= 1'b0;
            n++;
        end while (!b_v && n < 40);
        b_r <= 1'b0;
        err_total += (n >= 40);
        if (n >= 40)
            tally_and_finish();
    endtask : wr

    // Read: rready comes up after a random stall of up to two cycles
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        int n;
        int d;
        rq.push_back({a > 6'h20 ? 2'h2 : 2'h0, 16'h0000, e});
        d = $urandom_range(2);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= (d == 0);
        n = 0;
        do
        begin
            @(posedge aclk);
            if (ar_rdy)
                ar_v <= 1'b0;
            n++;
            if (n == d)
                r_r <= 1'b1;
        end while (!(r_v && r_r) && n < 40);
        r_r <= 1'b0;
        err_total += (n >= 40);
        if (n >= 40)
            tally_and_finish();
    endtask : rd

    // One-cycle raise of the chosen flags
    task automatic pulse(input logic [2:0] b);
        @(posedge aclk);
        go <= 1'b1;
        go_bits <= b;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : pulse

    // Scoreboard: oldest note against each response handed over
    always @(posedge aclk)
    begin
        if (r_v && r_r)
        begin
            rexp = rq.pop_front();
            `CHK("rdata", rexp[31:0], r_d)
            `CHK("rresp", rexp[33:32], r_rsp)
        end
        if (b_v && b_r)
        begin
            bexp = bq.pop_front();
            `CHK("bresp", bexp, b_rsp)
        end
    end

    // Main sequence
    initial
    begin
        void'($urandom(86834));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(6'(4 * i), 16'h0000);
        rd(6'h18, 16'h0444);
        rd(6'h24, 16'h0000);
        wr(6'h24, 16'hFFFF, 4'h3);
        $display("test reset and unmapped done");
        for (int i = 0; i < 4; i++)
        begin
            wr(6'(4 * i + 4), 16'hFFFF, 4'h1);
            rd(6'(4 * i + 4), msk[i] & 16'h00FF);
            wr(6'(4 * i + 4), 16'hFFFF, 4'hF);
            rd(6'(4 * i + 4), msk[i]);
        end
        wr(6'h00, 16'hFFFF, 4'h3);
        rd(6'h00, 16'h000E);
        $display("test register layout done");
        repeat (6)
        begin
            for (int i = 0; i < 4; i++)
            begin
                en_v[i] = 16'($urandom);
                wr(6'(4 * i + 4), en_v[i], 4'h3);
                rd(6'(4 * i + 4), en_v[i] & msk[i]);
            end
            gate = {en_v[3], en_v[2], en_v[1], en_v[0]} & {msk[3], msk[2], msk[1], msk[0]};
            lvl <= {$urandom, $urandom};
            repeat (3) @(posedge aclk);
            `CHK("enabled_request", lvl & gate, en_req)
        end
        $display("test enable gating done");
        wr(6'h00, 16'h0000, 4'h3);
        pulse(3'h1);
        rd(6'h00, 16'h0002);
        `CHK("forward_request", 3'h0, fwd)
        wr(6'h14, 16'h000E, 4'h3);
        repeat (2) @(posedge aclk);
        `CHK("forward_request", 3'h1, fwd)
        `CHK("forward_priority", 9'h004, fwd_p)
        pulse(3'h6);
        rd(6'h00, 16'h000E);
        wr(6'h18, 16'h0170, 4'h3);
        repeat (2) @(posedge aclk);
        `CHK("forward_request", 3'h6, fwd)
        `CHK("forward_priority", 9'h078, fwd_p)
        $display("test flags and priority done");
        wr(6'h20, 16'h0007, 4'h3);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b1, irq)
        wr(6'h20, 16'h0000, 4'h3);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        wr(6'h20, 16'h0007, 4'h3);
        wr(6'h00, 16'h0000, 4'h3);
        rd(6'h00, 16'h0000);
        rd(6'h1C, 16'h0007);
        rd(6'h1C, 16'h0000);
        repeat (2) @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        $display("test interrupt line done");
        // Clock enable low: requests change, flags and gated outputs stay frozen
        ce <= 1'b0;
        lvl <= ~lvl;
        pulse(3'h6);
        `CHK("enabled_request", ~lvl & gate, en_req)
        ce <= 1'b1;
        rd(6'h00, 16'h0000);
        repeat (3) @(posedge aclk);
        `CHK("enabled_request", lvl & gate, en_req)
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule : tb_interrupt_flag_enable_bank
